// *** iox_pkg.sv ***
// Constants, register map and state layout for the eight-bit I/O expander.
// Assumes an AXI4-Lite master with 32-bit data and the pin pads outside the block.
package iox_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int PORT_W  = 8;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int ASEL_W  = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_INPUT      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_POLARITY   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CONFIG     = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_BUS_ADDR   = 8'h18;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [PORT_W-1:0] CONFIG_RESET   = 8'hff;
  localparam logic [PORT_W-1:0] OUTPUT_RESET   = 8'hff;
  localparam logic [PORT_W-1:0] POLARITY_RESET = 8'h00;
  localparam logic [PORT_W-1:0] MASK_RESET     = 8'h00;
  localparam logic [PORT_W-1:0] PIN_OE_N_RESET = 8'hff;

  // Edges needed before the synchronised pins are valid after reset
  localparam logic [1:0] PRIME_LAST = 2'h3;

  // Fixed upper bits of the seven-bit target address; value is arbitrary
  localparam logic [3:0] TARGET_ADDR_UPPER = 4'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Whole module state
  typedef struct packed {
    logic [PORT_W-1:0] in_meta;
    logic [PORT_W-1:0] in_sync;
    logic [ASEL_W-1:0] asel_meta;
    logic [ASEL_W-1:0] asel_sync;
    logic [1:0]        prime_cnt;
    logic [PORT_W-1:0] input_snap;
    logic [PORT_W-1:0] output_reg;
    logic [PORT_W-1:0] polarity;
    logic [PORT_W-1:0] config_dir;
    logic [PORT_W-1:0] irq_status;
    logic [PORT_W-1:0] irq_mask;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [PORT_W-1:0] w_data;
    logic              w_strb0;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [DATA_W-1:0] rdata;
    logic [PORT_W-1:0] pin_out;
    logic [PORT_W-1:0] pin_oe_n;
    logic              change_int_oe_n;
    logic              irq;
  } iox_state_type;

endpackage : iox_pkg

// *** iox_expander.sv ***
// Eight-bit I/O expander core with AXI4-Lite registers and a change interrupt.
// Assumes pads resolve pin levels from the active-low output enables.
// Pin and address select inputs are asynchronous and pass two flip-flops first.
// The register map is this block's own; software reaches it over AXI4-Lite.
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps

// Functional notes
// [R1] After reset every port pin is an input and nothing is driven.
// [R2] Per-pin direction bits written by software steer each pin's driver.
// [R3] Input register holds sampled pin values; output register holds output values.
// [R4] A set polarity bit inverts that pin's level in the input register.
// [R5] All writable registers read back their last written value; irq_status instead reads sticky change bits, cleared by writing ones.
// [R6] Power-on reset loads defaults and idles the bus logic.
// [R7] Holding reset low repeats the same initialisation without power loss.
// [R8] Change interrupt asserts while any input differs from its input register bit.
// [R9] Bus address is formed partly from three address select inputs.
// [R10] Pin zero output is open-drain; pins one to seven are push-pull.
// [R11] Outputs keep their last written value until rewritten or reset.
// [R12] The bus target keeps working at serial rates up to fast mode.
// [R13] Interrupt releases once every input again matches its register bit.
// [R14] Low three address bits come from the select inputs, upper bits fixed.
module iox_expander
  import iox_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [PORT_W-1:0] port_in,
  output logic [PORT_W-1:0]      port_out,
  output logic [PORT_W-1:0]      port_oe_n,
  output logic                   change_int_oe_n,
  input  wire logic              addr_select_bit0,
  input  wire logic              addr_select_bit1,
  input  wire logic              addr_select_bit2,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // State
  // Anything not named resets to zero, so both bus channels start idle
  localparam iox_state_type RESET_STATE = '{
    config_dir:      CONFIG_RESET,
    output_reg:      OUTPUT_RESET,
    polarity:        POLARITY_RESET,
    irq_mask:        MASK_RESET,
    pin_oe_n:        PIN_OE_N_RESET,
    pin_out:         {OUTPUT_RESET[PORT_W-1:1], 1'b0},
    change_int_oe_n: 1'b1,
    default:         '0
  };

  iox_state_type state;
  iox_state_type next_state;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic [PORT_W-1:0] live;
    logic [PORT_W-1:0] mismatch;
    logic [PORT_W-1:0] rd8;
    logic              rd_ok;
    logic              wr_ok;
    logic              do_write;
    logic              ar_fire;
    live       = '0;
    mismatch   = '0;
    rd8        = '0;
    rd_ok      = 1'b0;
    wr_ok      = 1'b0;
    do_write   = 1'b0;
    ar_fire    = 1'b0;
    next_state = state;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin and address select synchronisers
    next_state.in_meta   = port_in;
    next_state.in_sync   = state.in_meta;
    next_state.asel_meta[0] = addr_select_bit0; // [R9]
    next_state.asel_meta[1] = addr_select_bit1; // [R9]
    next_state.asel_meta[2] = addr_select_bit2; // [R9]
    next_state.asel_sync = state.asel_meta;

    // Per-pin view as software sees it, and the change compare
    for (int i = 0; i < PORT_W; i++)
    begin
      live[i] = state.in_sync[i] ^ state.polarity[i]; // [R4]
      if (state.config_dir[i] && (state.prime_cnt == PRIME_LAST))
      begin
        mismatch[i] = live[i] ^ state.input_snap[i]; // [R8]
      end
      else
      begin
        mismatch[i] = 1'b0;
      end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Snapshot reloaded until the synchroniser holds real pin levels;
    // a snapshot of the reset zeros would raise a false change interrupt
    if (state.prime_cnt != PRIME_LAST)
    begin
      next_state.prime_cnt  = state.prime_cnt + 2'h1;
      next_state.input_snap = live; // [R3]
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write address and data, taken in either order
    if (s_axi_awvalid && state.awready)
    begin
      next_state.aw_got  = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state.wready)
    begin
      next_state.w_got   = 1'b1;
      next_state.w_data  = s_axi_wdata[PORT_W-1:0];
      next_state.w_strb0 = s_axi_wstrb[0];
    end

    // One write at a time: the next is not taken until its response is accepted
    do_write = state.aw_got && state.w_got && !state.bvalid;
    if (do_write)
    begin
      wr_ok = 1'b1;
      unique case (state.aw_addr)
        OFS_OUTPUT:
        begin
          if (state.w_strb0)
          begin
            next_state.output_reg = state.w_data; // [R11]
          end
        end
        OFS_POLARITY:
        begin
          if (state.w_strb0)
          begin
            next_state.polarity = state.w_data;
          end
        end
        OFS_CONFIG:
        begin
          if (state.w_strb0)
          begin
            next_state.config_dir = state.w_data; // [R2]
          end
        end
        OFS_IRQ_STATUS:
        begin
          if (state.w_strb0)
          begin
            next_state.irq_status = state.irq_status & ~state.w_data;
          end
        end
        OFS_IRQ_MASK:
        begin
          if (state.w_strb0)
          begin
            next_state.irq_mask = state.w_data;
          end
        end
        // Read-only registers ignore writes but still answer without error
        OFS_INPUT:
        begin
          wr_ok = 1'b1;
        end
        OFS_BUS_ADDR:
        begin
          wr_ok = 1'b1;
        end
        // Unmapped offsets answer with an error and change nothing
        default:
        begin
          wr_ok = 1'b0;
        end
      endcase
      next_state.aw_got = 1'b0;
      next_state.w_got  = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (state.bvalid && s_axi_bready)
    begin
      next_state.bvalid = 1'b0;
    end
    next_state.awready = !next_state.aw_got && !next_state.bvalid;
    next_state.wready  = !next_state.w_got && !next_state.bvalid;

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel; arready stays low while an answer stands
    ar_fire = s_axi_arvalid && state.arready;
    if (ar_fire)
    begin
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
        OFS_INPUT:
        begin
          rd8                   = live; // [R3]
          next_state.input_snap = live; // [R13]
        end
        OFS_OUTPUT:
        begin
          rd8 = state.output_reg; // [R5]
        end
        OFS_POLARITY:
        begin
          rd8 = state.polarity; // [R5]
        end
        OFS_CONFIG:
        begin
          rd8 = state.config_dir; // [R5]
        end
        OFS_IRQ_STATUS:
        begin
          rd8 = state.irq_status;
        end
        OFS_IRQ_MASK:
        begin
          rd8 = state.irq_mask;
        end
        OFS_BUS_ADDR:
        begin
          rd8 = {1'b0, TARGET_ADDR_UPPER, state.asel_sync}; // [R9] [R14]
        end
        // Unmapped reads answer zero with an error
        default:
        begin
          rd8   = '0;
          rd_ok = 1'b0;
        end
      endcase
      next_state.rvalid  = 1'b1;
      next_state.rdata   = {{(DATA_W-PORT_W){1'b0}}, rd8};
      next_state.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
      next_state.arready = 1'b0;
    end
    else if (state.rvalid && s_axi_rready)
    begin
      next_state.rvalid  = 1'b0;
      next_state.arready = 1'b1;
    end
    else if (!state.rvalid)
    begin
      next_state.arready = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky change status; a change in the clearing cycle is not lost
    for (int i = 0; i < PORT_W; i++)
    begin
      if (mismatch[i])
      begin
        next_state.irq_status[i] = 1'b1;
      end
    end
    next_state.irq = |(next_state.irq_status & next_state.irq_mask);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers: pin zero only ever pulls low, the others drive both levels
    for (int i = 0; i < PORT_W; i++)
    begin
      if (i == 0)
      begin
        next_state.pin_out[i]  = 1'b0; // [R10]
        next_state.pin_oe_n[i] = state.config_dir[i] | state.output_reg[i]; // [R1] [R2] [R10]
      end
      else
      begin
        next_state.pin_out[i]  = state.output_reg[i]; // [R11]
        next_state.pin_oe_n[i] = state.config_dir[i]; // [R1] [R2]
      end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Open-drain change interrupt
    next_state.change_int_oe_n = ~|mismatch; // [R8] [R13]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers; the core clock far outruns fast-mode serial rates
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Reset loads constants only; both bus channels return to idle
      state <= RESET_STATE; // [R6] [R7] [R1]
    end
    else
    begin
      state <= next_state; // [R12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Write channel
  assign s_axi_awready   = state.awready;
  assign s_axi_wready    = state.wready;
  assign s_axi_bresp     = state.bresp;
  assign s_axi_bvalid    = state.bvalid;

  // Read channel
  assign s_axi_arready   = state.arready;
  assign s_axi_rdata     = state.rdata;
  assign s_axi_rresp     = state.rresp;
  assign s_axi_rvalid    = state.rvalid;

  // Port pins
  assign port_out        = state.pin_out;
  assign port_oe_n       = state.pin_oe_n;

  // Interrupts
  assign change_int_oe_n = state.change_int_oe_n;
  assign irq             = state.irq;

endmodule : iox_expander

// *** iox_chk.sv ***
// Checker of bus handshake and pin timing of the expander.
// Assumes a bind onto iox_expander with ports matched by name.
`timescale 1ns/100ps
module iox_chk
  import iox_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [PORT_W-1:0] port_out,
  input wire logic [PORT_W-1:0] port_oe_n,
  input wire logic              change_int_oe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  property p_init; $rose(rst_n) |-> port_oe_n == 8'hff && change_int_oe_n; endproperty
  a_init: assert property (p_init) else $error("pins driven after reset");
  property p_od; port_out[0] == 1'b0; endproperty
  a_od: assert property (p_od) else $error("pin zero driven high");
  property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write response late");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rzero; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rzero: assert property (p_rzero) else $error("upper read bits set");
  property p_latch; !$stable({port_out, port_oe_n}) |-> $past(s_axi_bvalid); endproperty
  a_latch: assert property (p_latch) else $error("pins changed without write");
  c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_int: cover property (!change_int_oe_n);
  c_rd: cover property (s_axi_rvalid && s_axi_rdata != 32'h0);
endmodule : iox_chk

// *** iox_pins.sv ***
// Model of the board around the port pins and the interrupt line.
// Assumes a pull-up on pin zero and on the interrupt line.
`timescale 1ns/100ps
module iox_pins (
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_oe_n,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  input wire logic       change_int_oe_n,
  output logic [7:0]     pin_lvl,
  output logic           int_line
);
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!port_oe_n[i])
        pin_lvl[i] = port_out[i];
      else if (ext_en[i])
        pin_lvl[i] = ext_val[i];
      else
        pin_lvl[i] = (i == 0) ? 1'b1 : ~port_out[i];
    end
  end
  assign int_line = change_int_oe_n;
endmodule : iox_pins

// *** iox_expander_tb.sv ***
// Self-checking bench of the expander over its register bus.
// Assumes the pin model and checker files are compiled first.
`timescale 1ns/100ps
module iox_expander_tb
  import iox_pkg::*;
;
  logic clock = 1'b0, rst_n, awv, wv, bv, br, arv, arr, rv, rr, cio, irq, il;
  logic [7:0] awa, ara, po, poe, ev, ee, pl;
  logic [31:0] wd, rdat;
  logic [3:0] ws;
  logic [2:0] asel;
  logic [1:0] bre, rre;
  logic arr_w, wr_r;
  int err_total = 0, checks_done = 0;
  always #5 clock = ~clock;
  iox_expander iox_expander_inst (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(arr_w), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bre), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .port_in(pl), .port_out(po), .port_oe_n(poe), .change_int_oe_n(cio),
    .addr_select_bit0(asel[0]), .addr_select_bit1(asel[1]), .addr_select_bit2(asel[2]),
    .irq(irq));
  iox_pins iox_pins_inst (.port_out(po), .port_oe_n(poe), .ext_val(ev), .ext_en(ee),
    .change_int_oe_n(cio), .pin_lvl(pl), .int_line(il));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
    input logic [1:0] er);
    int n = 0;
    @(posedge clock);
    awa <= a; wd <= {24'h0, d}; ws <= s; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
      if (arr_w) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (!bv && n < 50);
    br <= 1'b0;
    if (!bv) err_total++;
    chk("bresp", {30'h0, bre}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    int n = 0;
    @(posedge clock);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
      if (arr) arv <= 1'b0;
    end while (!rv && n < 50);
    rr <= 1'b0;
    if (!rv) err_total++;
    chk("rresp", {30'h0, rre}, {30'h0, er});
    chk("rdata", rdat, {24'h0, e});
  endtask : rd
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0; awa = 0; ara = 0; wd = 0; ws = 0;
    ev = 8'ha0; ee = 8'hfe; asel = 3'b101;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk("oe", {24'h0, poe}, 32'hff);
    rd(OFS_OUTPUT, OUTPUT_RESET, RESP_OKAY);
    rd(OFS_POLARITY, POLARITY_RESET, RESP_OKAY);
    rd(OFS_CONFIG, CONFIG_RESET, RESP_OKAY);
    rd(OFS_IRQ_MASK, MASK_RESET, RESP_OKAY);
    rd(OFS_BUS_ADDR, {1'b0, TARGET_ADDR_UPPER, 3'b101}, RESP_OKAY);
    rd(OFS_IRQ_STATUS, 8'h00, RESP_OKAY);
    chk("int", {31'h0, il}, 32'h1);
    rd(8'h1c, 8'h00, RESP_SLVERR);
    rd(OFS_INPUT, 8'ha1, RESP_OKAY);
    wr(OFS_OUTPUT, 8'h5a, 4'h1, RESP_OKAY);
    wr(OFS_CONFIG, 8'hf0, 4'h1, RESP_OKAY);
    wr(OFS_POLARITY, 8'h30, 4'h1, RESP_OKAY);
    repeat (2) @(posedge clock);
    chk("oe", {24'h0, poe}, 32'hf0);
    chk("pins", {24'h0, pl}, 32'haa);
    rd(OFS_CONFIG, 8'hf0, RESP_OKAY);
    rd(OFS_POLARITY, 8'h30, RESP_OKAY);
    rd(OFS_INPUT, 8'h9a, RESP_OKAY);
    wr(OFS_IRQ_STATUS, 8'hff, 4'h1, RESP_OKAY);
    wr(OFS_IRQ_MASK, 8'hf0, 4'h1, RESP_OKAY);
    rd(OFS_IRQ_STATUS, 8'h00, RESP_OKAY);
    chk("int", {31'h0, il}, 32'h1);
    ev <= 8'h50;
    repeat (5) @(posedge clock);
    chk("int", {31'h0, il}, 32'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(OFS_IRQ_STATUS, 8'hf0, RESP_OKAY);
    rd(OFS_INPUT, 8'h6a, RESP_OKAY);
    repeat (2) @(posedge clock);
    chk("int", {31'h0, il}, 32'h1);
    wr(OFS_IRQ_STATUS, 8'hf0, 4'h1, RESP_OKAY);
    repeat (2) @(posedge clock);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(8'h20, 8'h01, 4'h1, RESP_SLVERR);
    wr(OFS_OUTPUT, 8'h00, 4'h0, RESP_OKAY);
    rd(OFS_OUTPUT, 8'h5a, RESP_OKAY);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk("oe", {24'h0, poe}, 32'hff);
    rd(OFS_OUTPUT, 8'hff, RESP_OKAY);
    rd(OFS_CONFIG, 8'hff, RESP_OKAY);
    rd(OFS_INPUT, 8'h51, RESP_OKAY);
    rd(OFS_IRQ_STATUS, 8'h00, RESP_OKAY);
    give_verdict();
  end
  initial
  begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule : iox_expander_tb
bind iox_expander iox_chk iox_chk_inst (.*);
